// ---- logic/pbc_pkg.sv ----
// package of register map, field layout and reset values for the power budget capability block
package pbc_pkg;
   localparam logic [11:0] ADDR_HEADER = 12'h20C;
   localparam logic [11:0] ADDR_SELECT = 12'h210;
   localparam logic [11:0] ADDR_DATA   = 12'h214;
   localparam logic [11:0] ADDR_ALLOC  = 12'h218;
   localparam logic [11:0] ADDR_LOAD   = 12'h21C;

   localparam logic [15:0] CAP_ID       = 16'h0004;
   localparam logic [3:0]  CAP_VERSION  = 4'h1;
   localparam logic [11:0] NEXT_UP      = 12'h230;
   localparam logic [11:0] NEXT_DOWN    = 12'h220;

   localparam logic [7:0]  SEL_RESET    = 8'h00;
   localparam logic [7:0]  SEL_D0_MAX   = 8'h00;
   localparam logic [7:0]  SEL_D0_SUST  = 8'h01;

   localparam logic [7:0]  BASE_RESET   = 8'h04;
   localparam logic [1:0]  SCALE_RESET  = 2'h0;
   localparam logic [2:0]  SUBST_RESET  = 3'h0;
   localparam logic [1:0]  PMST_RESET   = 2'h0;
   localparam logic [2:0]  TYPE_RESET   = 3'h7;
   localparam logic [2:0]  RAIL_RESET   = 3'h2;
   localparam logic        ALLOC_RESET  = 1'b0;

   // load port field positions
   localparam int LD_BASE_LSB  = 0;
   localparam int LD_ALLOC_BIT = 8;
   localparam int LD_STROBE    = 31;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- logic/pbc_regs.sv ----
// power budgeting capability register block behind an axi4-lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

module pbc_regs (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        upstream_port,
   input  wire logic        eeprom_load,
   input  wire logic [7:0]  eeprom_base_power,
   input  wire logic        eeprom_sys_alloc,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // write channel state
   logic        aw_held;
   logic [11:0] aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;

   // registers
   logic [7:0]  sel;
   logic [7:0]  base_power;
   logic        sys_alloc;
   logic        up_strap;

   // synchronised auto-load request and its edge detector
   logic        load_meta;
   logic        load_sync;
   logic        load_prev;
   logic        load_pulse;
   logic        soft_load;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == pbc_pkg::ADDR_HEADER) || (a == pbc_pkg::ADDR_SELECT) ||
               (a == pbc_pkg::ADDR_DATA)   || (a == pbc_pkg::ADDR_ALLOC) ||
               (a == pbc_pkg::ADDR_LOAD);
   endfunction

   function automatic logic [31:0] read_word(input logic [11:0] a);
      logic supported;
      supported = (sel == pbc_pkg::SEL_D0_MAX) || (sel == pbc_pkg::SEL_D0_SUST);
      read_word = 32'h0000_0000;
      case (a)
         pbc_pkg::ADDR_HEADER: begin
            read_word = {(up_strap ? pbc_pkg::NEXT_UP : pbc_pkg::NEXT_DOWN),
                         pbc_pkg::CAP_VERSION,
                         pbc_pkg::CAP_ID};
         end
         pbc_pkg::ADDR_SELECT: begin
            read_word = {24'h00_0000, sel};
         end
         pbc_pkg::ADDR_DATA: begin
            // both supported conditions share one descriptor set
            if (supported) begin
               read_word = {11'h000,
                            pbc_pkg::RAIL_RESET,
                            pbc_pkg::TYPE_RESET,
                            pbc_pkg::PMST_RESET,
                            pbc_pkg::SUBST_RESET,
                            pbc_pkg::SCALE_RESET,
                            base_power};
            end else begin
               read_word = 32'h0000_0000;
            end
         end
         pbc_pkg::ADDR_ALLOC: begin
            read_word = {31'h0000_0000, sys_alloc};
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   endfunction

   // the port role is a strap: caught after reset release, never under the async reset
   logic strap_done;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         strap_done <= 1'b0;
         up_strap   <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         up_strap   <= upstream_port;
      end
   end

   // eeprom_load comes from the loader's pins, so it is synchronised first
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         load_meta <= 1'b0;
         load_sync <= 1'b0;
         load_prev <= 1'b0;
      end else begin
         load_meta <= eeprom_load;
         load_sync <= load_meta;
         load_prev <= load_sync;
      end
   end
   assign load_pulse = load_sync && !load_prev;

   // write address and data are taken independently, in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= pbc_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_addr) ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // only the selector byte is writable; other bits are dropped
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel <= pbc_pkg::SEL_RESET;
      end else if (do_write && aw_addr == pbc_pkg::ADDR_SELECT && w_strb[0]) begin
         sel <= w_data[7:0];
      end
   end

   // a software write to the load word with its strobe bit set mimics the loader
   assign soft_load = do_write && aw_addr == pbc_pkg::ADDR_LOAD &&
                      w_strb[3] && w_data[pbc_pkg::LD_STROBE];

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         base_power <= pbc_pkg::BASE_RESET;
      end else if (load_pulse) begin
         base_power <= eeprom_base_power;
      end else if (soft_load && w_strb[0]) begin
         base_power <= w_data[pbc_pkg::LD_BASE_LSB +: 8];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sys_alloc <= pbc_pkg::ALLOC_RESET;
      end else if (load_pulse) begin
         sys_alloc <= eeprom_sys_alloc;
      end else if (soft_load && w_strb[1]) begin
         sys_alloc <= w_data[pbc_pkg::LD_ALLOC_BIT];
      end
   end

   // read channel: one read at a time, answer one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= pbc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= read_word(s_axi_araddr);
         s_axi_rresp  <= mapped(s_axi_araddr) ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ---- test/pbc_regs_checker.sv ----
// assertion checker for the power budget capability register block
`timescale 1ns/10ps
`default_nettype none
module pbc_regs_checker (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        upstream_port,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid
);
   wire ar_t = s_axi_arvalid && s_axi_arready;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_header_id: assert property (ar_t && s_axi_araddr == 12'h20C |=> s_axi_rdata[19:0] == 20'h10004)
      else $error("header id or version wrong");
   a_next_ptr: assert property (ar_t && s_axi_araddr == 12'h20C |=>
      s_axi_rdata[31:20] == (upstream_port ? 12'h230 : 12'h220)) else $error("next pointer wrong");
   a_data_fields: assert property (ar_t && s_axi_araddr == 12'h214 |=> s_axi_rdata[31:21] == 11'h0 &&
      (s_axi_rdata[20:8] == 13'h0 || s_axi_rdata[20:8] == 13'h0B80)) else $error("data fields wrong");
   a_alloc_rsvd: assert property (ar_t && s_axi_araddr == 12'h218 |=> s_axi_rdata[31:1] == 31'h0)
      else $error("allocation reserved bits set");
   a_unmapped_err: assert property (ar_t && (s_axi_araddr < 12'h20C || s_axi_araddr > 12'h21C) |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   a_read_answer: assert property (ar_t |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##[1:2] s_axi_bvalid) else $error("write answer late");
   a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
endmodule
bind pbc_regs pbc_regs_checker pbc_regs_checker_inst (.*);
`default_nettype wire

// ---- test/power_budget_capability_regs_tb.sv ----
// self-checking testbench for the power budget capability register block
`timescale 1ns/10ps
`default_nettype none
module power_budget_capability_regs_tb;
   logic        mclk = 0, rst = 1, upstream_port = 0, eeprom_load = 0, eeprom_sys_alloc = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb = 0;
   logic [7:0]  eeprom_base_power = 0, sel, base;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   int          fails = 0, samples_checked = 0, seed = 32'h944D0FB4;
   always #50 mclk = ~mclk;
   pbc_regs pbc_regs_inst (.*);
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      samples_checked++;
      if (g !== e) begin
         $display("Error %0t: got %h expected %h", $time, g, e);
         fails++;
      end
   endtask
   // er of x skips the response compare where no code is promised
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n = 0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      if (n >= 50) fails++;
      if (^er !== 1'bx) chk({s_axi_bresp, 32'h0}, {er, 32'h0});
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      int n = 0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      if (n >= 50) fails++;
      chk({s_axi_rresp, s_axi_rdata}, {er, e});
   endtask
   function automatic logic [31:0] exp_data(input logic [7:0] s, input logic [7:0] b);
      return (s < 8'h02) ? {11'h0, pbc_pkg::RAIL_RESET, pbc_pkg::TYPE_RESET, pbc_pkg::PMST_RESET,
                            pbc_pkg::SUBST_RESET, pbc_pkg::SCALE_RESET, b} : 32'h0;
   endfunction
   task automatic do_reset(input logic up);
      @(posedge mclk);
      rst <= 1'b1;
      upstream_port <= up;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   task print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      do_reset(1'b0);
      rdc(12'h20C, 32'h22010004);
      rdc(12'h210, 32'h0);
      rdc(12'h214, 32'h000B8004);
      rdc(12'h218, 32'h0);
      base = 8'h04;
      for (int i = 0; i < 16; i++) begin
         sel = (i < 2) ? i[7:0] : 8'($random(seed));
         rd = $random(seed);
         wr(12'h210, {rd[31:8], sel}, 4'hF, 2'h0);
         rdc(12'h210, {24'h0, sel});
         rdc(12'h214, exp_data(sel, base));
         wr(i[0] ? 12'h218 : 12'h214, rd, 4'hF, 2'bxx);
         wr(12'h300 | {2'h0, rd[9:2], 2'h0}, rd, 4'hF, pbc_pkg::RESP_SLVERR);
         rdc(12'h1F0, 32'h0, pbc_pkg::RESP_SLVERR);
      end
      rdc(12'h218, 32'h0);
      wr(12'h210, 32'h0, 4'hF, 2'h0);
      eeprom_base_power <= 8'($random(seed));
      eeprom_sys_alloc <= 1'b1;
      eeprom_load <= 1'b1;
      repeat (4) @(posedge mclk);
      rdc(12'h214, exp_data(8'h00, eeprom_base_power));
      rdc(12'h218, 32'h1);
      eeprom_load <= 1'b0;
      wr(12'h21C, 32'h8000005A, 4'hF, 2'h0);
      rdc(12'h214, exp_data(8'h00, 8'h5A));
      rdc(12'h218, 32'h0);
      do_reset(1'b1);
      rdc(12'h20C, 32'h23010004);
      rdc(12'h214, 32'h000B8004);
      print_verdict;
   end
   // about fifty times the expected run
   initial begin
      #2000000;
      fails++;
      print_verdict;
   end
endmodule
`default_nettype wire
